//--- logic/sars_pkg.sv
package sars_pkg;

    // ---------------------------------------------------------------
    // Widths and codes
    // ---------------------------------------------------------------
    localparam int RES_W = 10;
    localparam int CH_W = 5;
    localparam logic [4:0] CH_IDLE = 5'h1f;
    localparam logic [9:0] FULL10 = 10'h3ff;
    localparam logic [9:0] FULL8 = 10'h0ff;
    localparam logic [9:0] ZERO10 = 10'h000;
    localparam logic [7:0] RESH_RST = 8'h00;
    localparam logic [7:0] RESL_RST = 8'h00;

    // ---------------------------------------------------------------
    // Timing in converter clocks, bus clocks, microseconds and MHz
    // ---------------------------------------------------------------
    localparam logic [5:0] SYNC_BUS = 6'h03;
    localparam logic [5:0] SAMP_SHORT = 6'h04;
    localparam logic [5:0] SAMP_LONG = 6'h18;
    localparam logic [5:0] CONV_10 = 6'h0f;
    localparam logic [5:0] CONV_8 = 6'h0c;
    localparam int ASYNC_START_US = 5;
    localparam int CLK_MHZ = 100;
    localparam int ASYNC_START_CYC = ASYNC_START_US * CLK_MHZ;
    localparam int ASYNC_FAST_MHZ = 2;
    localparam int ASYNC_SLOW_MHZ = 1;
    localparam logic [7:0] ASYNC_DIV_FAST =
        8'(CLK_MHZ / ASYNC_FAST_MHZ - 1);
    localparam logic [7:0] ASYNC_DIV_SLOW =
        8'(CLK_MHZ / ASYNC_SLOW_MHZ - 1);

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SARS_IDLE = 3'b000,
        SARS_SYNC = 3'b001,
        SARS_WARM = 3'b010,
        SARS_SAMPLE = 3'b011,
        SARS_CONVERT = 3'b100,
        SARS_XFER = 3'b101
    } sars_state_e;

    typedef struct packed {
        logic [4:0] channel_select_field;
        logic continuous_conv_enable;
        logic conv_irq_enable;
    } sars_status_ctl_s;

    typedef struct packed {
        logic low_power_config;
        logic [1:0] clock_divide_field;
        logic long_sample_select;
        logic mode_8bit;
        logic async_clk_enable;
        logic input_clock_select;
    } sars_clk_cfg_s;

endpackage : sars_pkg

//--- logic/sars_top.sv
`timescale 1ns/1ps

module sars_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register writes and result reads
    input wire logic sc_write_i,
    input wire sars_pkg::sars_status_ctl_s sc_data_i,
    input wire logic clk_cfg_write_i,
    input wire sars_pkg::sars_clk_cfg_s clk_cfg_data_i,
    input wire logic res_high_read_i,
    input wire logic res_low_read_i,
    // System
    input wire logic stop_mode_i,
    input wire logic alt_clk_i,
    // Analog comparator, asynchronous
    input wire logic comparator_i,
    // Analog front end
    output logic [4:0] selected_analog_input_o,
    output logic [9:0] dac_code_o,
    output logic analog_on_o,
    output logic sample_o,
    // Results and status
    output logic [7:0] result_high_reg_o,
    output logic [7:0] result_low_reg_o,
    output logic conv_complete_flag_o,
    output logic conv_irq_o,
    output logic active_o
);

    // ---------------------------------------------------------------
    // Synchronisers
    // ---------------------------------------------------------------
    logic cmp_s1, cmp_s2, alt_s1, alt_s2, alt_s3;
    logic next_cmp_s1, next_cmp_s2, next_alt_s1, next_alt_s2, next_alt_s3;

    always_comb begin
        next_cmp_s1 = comparator_i;
        next_cmp_s2 = cmp_s1;
        next_alt_s1 = alt_clk_i;
        next_alt_s2 = alt_s1;
        next_alt_s3 = alt_s2;
    end

    always_ff @(posedge clk_i) begin
        cmp_s1 <= next_cmp_s1;
        cmp_s2 <= next_cmp_s2;
        alt_s1 <= next_alt_s1;
        alt_s2 <= next_alt_s2;
        alt_s3 <= next_alt_s3;
    end

    // ---------------------------------------------------------------
    // Configuration
    // ---------------------------------------------------------------
    sars_pkg::sars_status_ctl_s sc, next_sc;
    sars_pkg::sars_clk_cfg_s cfg, next_cfg;
    logic start_req, abort;

    always_comb begin
        next_sc = sc_write_i ? sc_data_i : sc;
        next_cfg = clk_cfg_write_i ? clk_cfg_data_i : cfg;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sc <= '{sars_pkg::CH_IDLE, 1'b0, 1'b0};
            cfg <= '0;
        end else begin
            sc <= next_sc;
            cfg <= next_cfg;
        end
    end

    // A write restarts unless it parks the channel field
    assign start_req = sc_write_i &&
        sc_data_i.channel_select_field != sars_pkg::CH_IDLE;
    assign abort = sc_write_i || clk_cfg_write_i ||
        (stop_mode_i && !cfg.async_clk_enable);

    // ---------------------------------------------------------------
    // Clock select and divide
    // ---------------------------------------------------------------
    sars_pkg::sars_state_e state, next_state;
    logic [7:0] async_cnt, next_async_cnt;
    logic [2:0] div_cnt, next_div_cnt;
    logic async_tick, src_tick, ck_tick;

    // Async oscillator only runs while converting; stop does not gate it
    always_comb begin
        async_tick = 1'b0;
        next_async_cnt = 8'h00;
        if (state != sars_pkg::SARS_IDLE && cfg.async_clk_enable) begin
            async_tick = async_cnt == (cfg.low_power_config ?
                sars_pkg::ASYNC_DIV_SLOW : sars_pkg::ASYNC_DIV_FAST);
            next_async_cnt = async_tick ? 8'h00 : async_cnt + 8'h01;
        end
    end

    always_comb begin
        if (cfg.async_clk_enable) begin
            src_tick = async_tick;
        end else if (cfg.input_clock_select) begin
            src_tick = 1'b1;
        end else begin
            src_tick = alt_s2 && !alt_s3;
        end
    end

    always_comb begin
        ck_tick = 1'b0;
        next_div_cnt = div_cnt;
        if (state == sars_pkg::SARS_IDLE) begin
            next_div_cnt = 3'h0;
        end else if (src_tick) begin
            ck_tick = div_cnt ==
                3'((4'h1 << cfg.clock_divide_field) - 4'h1);
            next_div_cnt = ck_tick ? 3'h0 : div_cnt + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            async_cnt <= 8'h00;
            div_cnt <= 3'h0;
        end else begin
            async_cnt <= next_async_cnt;
            div_cnt <= next_div_cnt;
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    logic [15:0] cnt, next_cnt;
    logic [9:0] sar, next_sar;
    logic [3:0] bit_idx, next_bit_idx;
    logic high_read, next_high_read;
    logic [7:0] res_h, next_res_h, res_l, next_res_l;
    logic conv_complete_flag, next_conv_complete_flag, irq, next_irq;
    logic [9:0] rounded;
    logic [5:0] samp_len;
    logic blocked;

    assign samp_len = cfg.long_sample_select ?
        sars_pkg::SAMP_LONG : sars_pkg::SAMP_SHORT;
    // 8-bit rounding saturates so full scale stays all ones
    assign rounded = !cfg.mode_8bit ? sar :
        (sar[9:2] == 8'hff || !sar[1]) ? {2'b00, sar[9:2]} :
        {2'b00, sar[9:2] + 8'h01};
    assign blocked = !cfg.mode_8bit && high_read;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sar = sar;
        next_bit_idx = bit_idx;
        next_res_h = res_h;
        next_res_l = res_l;
        next_conv_complete_flag = conv_complete_flag;
        next_irq = 1'b0;
        next_high_read = high_read;
        // Low read releases the guard, also when both reads coincide
        if (res_high_read_i || res_low_read_i) begin
            next_high_read = res_high_read_i && !res_low_read_i;
            next_conv_complete_flag = 1'b0;
        end
        case (state)
            sars_pkg::SARS_SYNC: begin
                next_cnt = cnt + 16'h0001;
                if (cnt[5:0] == sars_pkg::SYNC_BUS - 6'h1) begin
                    next_cnt = 16'h0000;
                    next_state = cfg.async_clk_enable ?
                        sars_pkg::SARS_WARM : sars_pkg::SARS_SAMPLE;
                end
            end
            sars_pkg::SARS_WARM: begin
                next_cnt = cnt + 16'h0001;
                if (cnt == 16'(sars_pkg::ASYNC_START_CYC - 1)) begin
                    next_cnt = 16'h0000;
                    next_state = sars_pkg::SARS_SAMPLE;
                end
            end
            sars_pkg::SARS_SAMPLE: begin
                if (ck_tick) begin
                    next_cnt = cnt + 16'h0001;
                    if (cnt[5:0] == samp_len - 6'h1) begin
                        next_cnt = 16'h0000;
                        next_sar = 10'h200;
                        next_bit_idx = 4'h9;
                        next_state = sars_pkg::SARS_CONVERT;
                    end
                end
            end
            sars_pkg::SARS_CONVERT: begin
                if (ck_tick) begin
                    if (!cmp_s2) begin
                        next_sar[bit_idx] = 1'b0;
                    end
                    if (bit_idx != 4'h0) begin
                        next_sar[bit_idx - 4'h1] = 1'b1;
                        next_bit_idx = bit_idx - 4'h1;
                    end else begin
                        next_state = sars_pkg::SARS_XFER;
                    end
                end
            end
            sars_pkg::SARS_XFER: begin
                if (!blocked) begin
                    next_res_h = {6'h00, rounded[9:8]};
                    next_res_l = rounded[7:0];
                    next_conv_complete_flag = 1'b1;
                    next_irq = sc.conv_irq_enable && !sc_write_i;
                end
                if (blocked || sc.continuous_conv_enable) begin
                    next_state = sars_pkg::SARS_SAMPLE;
                end else begin
                    next_state = sars_pkg::SARS_IDLE;
                end
            end
            default: next_state = sars_pkg::SARS_IDLE;
        endcase
        if (abort) begin
            next_state = sars_pkg::SARS_IDLE;
            next_cnt = 16'h0000;
            if (sc_write_i) begin
                next_conv_complete_flag = 1'b0;
            end
        end
        if (start_req) begin
            next_state = sars_pkg::SARS_SYNC;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= sars_pkg::SARS_IDLE;
            cnt <= 16'h0000;
            sar <= 10'h000;
            bit_idx <= 4'h0;
            high_read <= 1'b0;
            res_h <= sars_pkg::RESH_RST;
            res_l <= sars_pkg::RESL_RST;
            conv_complete_flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sar <= next_sar;
            bit_idx <= next_bit_idx;
            high_read <= next_high_read;
            res_h <= next_res_h;
            res_l <= next_res_l;
            conv_complete_flag <= next_conv_complete_flag;
            irq <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            selected_analog_input_o <= sars_pkg::CH_IDLE;
            dac_code_o <= 10'h000;
            analog_on_o <= 1'b0;
            sample_o <= 1'b0;
        end else begin
            selected_analog_input_o <= next_sc.channel_select_field;
            dac_code_o <= next_sar;
            analog_on_o <= next_state != sars_pkg::SARS_IDLE;
            sample_o <= next_state == sars_pkg::SARS_SAMPLE;
        end
    end

    assign result_high_reg_o = res_h;
    assign result_low_reg_o = res_l;
    assign conv_complete_flag_o = conv_complete_flag;
    assign conv_irq_o = irq;
    assign active_o = analog_on_o;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_abort_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (abort && !start_req) |=> state == sars_pkg::SARS_IDLE)
        else $error("abort did not idle");
    a_start_sync: assert property (@(posedge clk_i) disable iff (reset_i)
        start_req |=> state == sars_pkg::SARS_SYNC)
        else $error("write did not start");
    a_block_keep: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == sars_pkg::SARS_XFER && blocked && !abort)
        |=> $stable(res_l) && state == sars_pkg::SARS_SAMPLE)
        else $error("blocked transfer misbehaved");
    a_xfer_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == sars_pkg::SARS_XFER && !blocked && !abort
        && !res_high_read_i && !res_low_read_i) |=> conv_complete_flag)
        else $error("flag not set");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        irq |-> conv_complete_flag && sc.conv_irq_enable)
        else $error("interrupt without flag");
    a_idle_off: assert property (@(posedge clk_i) disable iff (reset_i)
        state == sars_pkg::SARS_IDLE |-> !ck_tick)
        else $error("clock runs when idle");
    a_mode8_high: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == sars_pkg::SARS_XFER && cfg.mode_8bit && !abort)
        |=> res_h == 8'h00)
        else $error("8-bit high not zero");
    sequence s_sync_run;
        start_req ##1 (!abort) [*3];
    endsequence
    a_sync_len: assert property (@(posedge clk_i) disable iff (reset_i)
        s_sync_run |=> state != sars_pkg::SARS_SYNC)
        else $error("sync too long");

endmodule : sars_top

//--- tb/sars_top_tb.sv
`timescale 1ns/1ps

module sars_top_tb;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    localparam int LIMIT = 60000;
    logic clk_i, reset_i, sc_write_i, clk_cfg_write_i;
    logic res_high_read_i, res_low_read_i, stop_mode_i;
    logic alt_clk_i, comparator_i, analog_on_o, sample_o;
    sars_pkg::sars_status_ctl_s sc_data_i;
    sars_pkg::sars_clk_cfg_s clk_cfg_data_i;
    logic [4:0] selected_analog_input_o, mux_seen;
    logic [9:0] dac_code_o;
    logic [7:0] result_high_reg_o, result_low_reg_o;
    logic conv_complete_flag_o, conv_irq_o, active_o, smp_seen;
    int err_total, checks, cyc, irq_cnt, irq_prev, irq_gap, alt_cnt, t, n;

    sars_top dut (
        .clk_i(clk_i), .reset_i(reset_i),
        .sc_write_i(sc_write_i), .sc_data_i(sc_data_i),
        .clk_cfg_write_i(clk_cfg_write_i),
        .clk_cfg_data_i(clk_cfg_data_i),
        .res_high_read_i(res_high_read_i),
        .res_low_read_i(res_low_read_i),
        .stop_mode_i(stop_mode_i), .alt_clk_i(alt_clk_i),
        .comparator_i(comparator_i),
        .selected_analog_input_o(selected_analog_input_o),
        .dac_code_o(dac_code_o), .analog_on_o(analog_on_o),
        .sample_o(sample_o), .result_high_reg_o(result_high_reg_o),
        .result_low_reg_o(result_low_reg_o),
        .conv_complete_flag_o(conv_complete_flag_o),
        .conv_irq_o(conv_irq_o), .active_o(active_o)
    );

    // ---------------------------------------------------------------
    // Clock, alternate clock of period 6, irq monitor, timeout
    // ---------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        alt_cnt <= (alt_cnt == 2) ? 0 : alt_cnt + 1;
        if (alt_cnt == 2) alt_clk_i <= ~alt_clk_i;
        cyc = cyc + 1;
        if (conv_irq_o === 1'b1) begin
            irq_cnt = irq_cnt + 1;
            irq_gap = cyc - irq_prev;
            irq_prev = cyc;
        end
        if (cyc == LIMIT) begin
            err_total = err_total + 1;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic write_sc(input logic [4:0] ch, input logic co,
            input logic ie);
        @(posedge clk_i);
        sc_write_i <= 1'b1;
        sc_data_i <= '{channel_select_field: ch,
            continuous_conv_enable: co, conv_irq_enable: ie};
        @(posedge clk_i);
        sc_write_i <= 1'b0;
    endtask : write_sc

    task automatic cfg(input logic lp, input logic [1:0] dv,
            input logic lng, input logic m8, input logic aen,
            input logic bus);
        @(posedge clk_i);
        clk_cfg_write_i <= 1'b1;
        clk_cfg_data_i <= '{low_power_config: lp, clock_divide_field: dv,
            long_sample_select: lng, mode_8bit: m8,
            async_clk_enable: aen, input_clock_select: bus};
        @(posedge clk_i);
        clk_cfg_write_i <= 1'b0;
    endtask : cfg

    task automatic read_res(input logic hi);
        @(posedge clk_i);
        res_high_read_i <= hi;
        res_low_read_i <= ~hi;
        @(posedge clk_i);
        res_high_read_i <= 1'b0;
        res_low_read_i <= 1'b0;
    endtask : read_res

    task automatic wait_flag(input int lim, output int tw);
        tw = 0;
        // Let the flag clear of the starting write settle first
        #1;
        while (conv_complete_flag_o !== 1'b1 && tw < lim) begin
            @(posedge clk_i);
            #1;
            tw = tw + 1;
            if (tw == 2) mux_seen = selected_analog_input_o;
            if (tw == 4) smp_seen = sample_o;
        end
        check(16'(tw < lim), 16'h0001);
    endtask : wait_flag

    task automatic timing(input logic lp, input logic [1:0] dv,
            input logic lng, input logic m8, input logic aen,
            input logic bus, input int per);
        int lo, hi, i0;
        lo = ((lng ? 23 : 3) + (m8 ? 8 : 10)) * per;
        hi = ((lng ? 41 : 21) - (m8 ? 3 : 0)) * per + 3 + per + 6;
        hi = hi + (aen ? 500 : 0);
        cfg(lp, dv, lng, m8, aen, bus);
        i0 = irq_cnt;
        write_sc(5'h03, 1'b0, 1'b0);
        wait_flag(4000, t);
        check(16'(t >= lo && t <= hi), 16'h0001);
        check(16'(dac_code_o), 16'h03ff);
        check(16'(smp_seen), 16'(!aen));
        check({result_high_reg_o, result_low_reg_o},
            m8 ? 16'h00ff : 16'h03ff);
        check(16'(mux_seen), 16'h0003);
        check(16'(irq_cnt - i0), 16'h0000);
    endtask : timing

    task automatic wait_irq(input int cnt);
        int k;
        k = 0;
        while (irq_cnt < cnt && k < 400) begin
            @(posedge clk_i);
            #1;
            k = k + 1;
        end
        check(16'(irq_cnt >= cnt), 16'h0001);
    endtask : wait_irq

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {sc_write_i, clk_cfg_write_i, res_high_read_i} = 3'h0;
        {res_low_read_i, stop_mode_i, alt_clk_i, comparator_i} = 4'h0;
        sc_data_i = '0;
        clk_cfg_data_i = '0;
        {err_total, checks, cyc, irq_cnt, irq_prev, irq_gap} = '0;
        alt_cnt = 0;
        reset_i = 1'b1;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (50) @(posedge clk_i);
        #1;
        check(16'(active_o), 16'h0000);
        check(16'(selected_analog_input_o), 16'h001f);
        comparator_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            timing(1'b0, 2'h0, i[1], i[0], 1'b0, 1'b1, 1);
        end
        for (int d = 1; d < 4; d++) begin
            timing(1'b0, 2'(d), 1'b0, 1'b0, 1'b0, 1'b1, 1 << d);
        end
        timing(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 6);
        timing(1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 50);
        timing(1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 100);
        // Stop does not abort while the async clock is enabled
        write_sc(5'h03, 1'b0, 1'b0);
        repeat (20) @(posedge clk_i);
        stop_mode_i <= 1'b1;
        wait_flag(4000, t);
        stop_mode_i <= 1'b0;
        check(16'(conv_complete_flag_o), 16'h0001);
        cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        // Restart by a second write, zero input, interrupt enabled
        comparator_i <= 1'b0;
        write_sc(5'h03, 1'b0, 1'b1);
        repeat (8) @(posedge clk_i);
        n = irq_cnt;
        write_sc(5'h03, 1'b0, 1'b1);
        wait_flag(200, t);
        check(16'(t <= 27), 16'h0001);
        check({result_high_reg_o, result_low_reg_o}, 16'h0000);
        @(posedge clk_i);
        #1;
        check(16'(irq_cnt - n), 16'h0001);
        // High read without low read blocks the transfer
        read_res(1'b1);
        comparator_i <= 1'b1;
        write_sc(5'h03, 1'b0, 1'b0);
        repeat (80) @(posedge clk_i);
        #1;
        check(16'(conv_complete_flag_o), 16'h0000);
        check({result_high_reg_o, result_low_reg_o}, 16'h0000);
        check(16'(active_o), 16'h0001);
        read_res(1'b0);
        wait_flag(100, t);
        check({result_high_reg_o, result_low_reg_o}, 16'h03ff);
        // Aborts: stop, clock config write, idle channel write
        comparator_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            write_sc(5'h03, 1'b0, 1'b0);
            repeat (5) @(posedge clk_i);
            if (k == 0) stop_mode_i <= 1'b1;
            if (k == 1) cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
            if (k == 2) write_sc(5'h1f, 1'b0, 1'b0);
            repeat (3) @(posedge clk_i);
            #1;
            check(16'(active_o), 16'h0000);
            check(16'(analog_on_o), 16'h0000);
            repeat (60) @(posedge clk_i);
            #1;
            check(16'(conv_complete_flag_o), 16'h0000);
            check({result_high_reg_o, result_low_reg_o}, 16'h03ff);
            stop_mode_i <= 1'b0;
        end
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({result_high_reg_o, result_low_reg_o}, 16'h0000);
        check(16'(selected_analog_input_o), 16'h001f);
        // Continuous conversions and the gap between them
        cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        n = irq_cnt;
        write_sc(5'h03, 1'b1, 1'b1);
        wait_irq(n + 1);
        for (int j = 2; j < 4; j++) begin
            wait_irq(n + j);
            check(16'(irq_gap >= 13 && irq_gap <= 21), 16'h0001);
        end
        write_sc(5'h1f, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        check(16'(active_o), 16'h0000);
        final_report();
    end

endmodule : sars_top_tb
